// ===== rtl/rom_card_params.svh
// Constants for the speech ROM card address demultiplexer.
// Assumes a single 50 MHz core clock and synchronous active-high reset.
`ifndef ROM_CARD_PARAMS_SVH
`define ROM_CARD_PARAMS_SVH

`define BUS_W          8
`define ADDR_W         20
`define HIGH_W         4
`define HIGH_RST       4'h0
`define MED_RST        8'h00
`define LOW_RST        8'h00
`define DATA_RST       8'h00
`define CARD_BYTES     20'h4_0000
`define VCARD_BIT      17
`define ROW_LSB        14
`define DEVICES        16
`define BLK_LSB        18

`endif

// ===== rtl/rom_card_pkg.sv
// Types shared by the speech ROM card address demultiplexer.
// Assumes the constants header is on the include path.
`include "rom_card_params.svh"
package rom_card_pkg;
   typedef logic [`BUS_W-1:0]   bus_byte_t;
   typedef logic [`ADDR_W-1:0]  mem_addr_t;
   typedef logic [`DEVICES-1:0] dev_sel_t;
endpackage

// ===== rtl/speech_rom_card_address_mux.sv
// Address demultiplexer and decoder of the speech ROM card.
// Assumes every backplane pin, the direction line included, is asynchronous
// and is synchronised here, while memory read data comes from core_clk_in logic.
// Functional notes
// - Rebuild 20-bit address from 8-bit transfers.
// - High load captures bus into high latch.
// - Medium load captures bus into medium latch.
// - Low byte taken live from the bus.
// - Decode table yields chip and write enables.
// - Card enable only inside memory range.
// - Read strobe gates output enables; row gives chip enables.
// - Read data driven only with strobe and enable.
// - 256 kbytes as two virtual cards.
`timescale 1ns/1ps
`include "rom_card_params.svh"
module speech_rom_card_address_mux
(
   input  wire logic                     core_clk_in,
   input  wire logic                     sys_rst_in,
   input  wire rom_card_pkg::bus_byte_t  bus_data_in,
   input  wire logic                     load_high_in,
   input  wire logic                     load_med_in,
   input  wire logic                     data_strobe_in,
   input  wire logic                     write_in,
   input  wire logic [2:0]               card_block_number_in,
   input  wire rom_card_pkg::bus_byte_t  mem_rdata_in,
   output logic                          card_enable_out,
   output rom_card_pkg::mem_addr_t       mem_addr_out,
   output rom_card_pkg::dev_sel_t        chip_enable_out,
   output rom_card_pkg::dev_sel_t        output_enable_out,
   output rom_card_pkg::dev_sel_t        write_enable_out,
   output logic                          virtual_card_out,
   output rom_card_pkg::bus_byte_t       bus_data_out,
   output logic                          bus_data_oe_n_out
);
   import rom_card_pkg::*;

   // ==================================================================
   // Pin synchronisers
   // ==================================================================
   // Every backplane pin passes two flops; only the second stage is read.
   bus_byte_t        bus_s1_ff, bus_s2_ff;
   logic [2:0]       str_s1_ff, str_s2_ff;
   logic [2:0]       blk_s1_ff, blk_s2_ff;
   logic             wr_s1_ff, wr_s2_ff;

   // Two-stage capture of bus and strobes.
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         bus_s1_ff <= `LOW_RST;
         bus_s2_ff <= `LOW_RST;
         str_s1_ff <= 3'h0;
         str_s2_ff <= 3'h0;
         blk_s1_ff <= 3'h0;
         blk_s2_ff <= 3'h0;
         wr_s1_ff  <= 1'b0;
         wr_s2_ff  <= 1'b0;
      end
      else
      begin
         bus_s1_ff <= bus_data_in;
         bus_s2_ff <= bus_s1_ff;
         str_s1_ff <= {load_high_in, load_med_in, data_strobe_in};
         str_s2_ff <= str_s1_ff;
         blk_s1_ff <= card_block_number_in;
         blk_s2_ff <= blk_s1_ff;
         // Direction travels with the strobe, so both reach the decode together.
         wr_s1_ff  <= write_in;
         wr_s2_ff  <= wr_s1_ff;
      end
   end

   // ==================================================================
   // Address latches
   // ==================================================================
   logic [`HIGH_W-1:0] high_ff;
   bus_byte_t          med_ff;

   // Latches change only on their own load, so data reads within a page
   // need only a fresh low byte.
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         high_ff <= `HIGH_RST;
         med_ff  <= `MED_RST;
      end
      else
      begin
         if (str_s2_ff[2])
            high_ff <= bus_s2_ff[`HIGH_W-1:0];
         if (str_s2_ff[1])
            med_ff <= bus_s2_ff;
      end
   end

   // ==================================================================
   // Address assembly and decode table
   // ==================================================================
   mem_addr_t  nxt_addr;
   logic       nxt_in_range;
   dev_sel_t   nxt_dev;
   logic       strobe_ok;
   logic       bus_is_load;

   // The low byte is the live bus, never latched.
   assign nxt_addr = {high_ff, med_ff, bus_s2_ff};
   // The top two bits select the card block; the switch names ours.
   assign nxt_in_range = ({1'b0, nxt_addr[`ADDR_W-1:`BLK_LSB]} == blk_s2_ff);
   assign bus_is_load  = str_s2_ff[2] | str_s2_ff[1];
   assign strobe_ok    = str_s2_ff[0] & ~bus_is_load;

   // Table lookup: one device per 16 kbyte row across 256 kbytes.
   generate
      for (genvar i = 0; i < `DEVICES; i++)
      begin : g_dev
         assign nxt_dev[i] = nxt_in_range
                             & (nxt_addr[`BLK_LSB-1:`ROW_LSB] == 4'(i));
      end
   endgenerate

   // ==================================================================
   // Registered memory-side outputs
   // ==================================================================
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         card_enable_out   <= 1'b0;
         mem_addr_out      <= '0;
         chip_enable_out   <= '0;
         output_enable_out <= '0;
         write_enable_out  <= '0;
         virtual_card_out  <= 1'b0;
      end
      else
      begin
         card_enable_out   <= nxt_in_range;
         mem_addr_out      <= nxt_addr;
         chip_enable_out   <= nxt_dev;
         // Outputs open only for reads under strobe; a ROM never writes,
         // but the table keeps the write lines for RAM variants.
         output_enable_out <= (strobe_ok & ~wr_s2_ff) ? nxt_dev : '0;
         write_enable_out  <= (strobe_ok & wr_s2_ff) ? nxt_dev : '0;
         virtual_card_out  <= nxt_addr[`VCARD_BIT];
      end
   end

   // ==================================================================
   // Backplane data buffer
   // ==================================================================
   // Drives only while strobe and card enable agree; enable low = drive.
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         bus_data_out      <= `DATA_RST;
         bus_data_oe_n_out <= 1'b1;
      end
      else
      begin
         bus_data_out      <= mem_rdata_in;
         bus_data_oe_n_out <= ~(strobe_ok & ~wr_s2_ff & nxt_in_range);
      end
   end

   // ==================================================================
   // Assertions
   // ==================================================================
   property p_high_load;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      str_s2_ff[2] |=> high_ff == $past(bus_s2_ff[`HIGH_W-1:0]);
   endproperty
   a_high_load: assert property (p_high_load) else $error("high latch missed load");

   property p_med_load;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      str_s2_ff[1] |=> med_ff == $past(bus_s2_ff);
   endproperty
   a_med_load: assert property (p_med_load) else $error("medium latch missed load");

   property p_hold;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      !str_s2_ff[2] && !str_s2_ff[1] |=> $stable(high_ff) && $stable(med_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("latch changed without load");

   property p_addr;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      1 |=> mem_addr_out == {$past(high_ff), $past(med_ff), $past(bus_s2_ff)};
   endproperty
   a_addr: assert property (p_addr) else $error("address assembled wrong");

   property p_range;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      card_enable_out |-> mem_addr_out[`ADDR_W-1:`BLK_LSB] == $past(blk_s2_ff[1:0]) && !$past(blk_s2_ff[2]);
   endproperty
   a_range: assert property (p_range) else $error("card enabled out of range");

   property p_one_ce;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      $onehot0(chip_enable_out) && (card_enable_out == (chip_enable_out != '0));
   endproperty
   a_one_ce: assert property (p_one_ce) else $error("chip enables disagree");

   property p_oe_in_ce;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      (output_enable_out & ~chip_enable_out) == '0;
   endproperty
   a_oe_in_ce: assert property (p_oe_in_ce) else $error("output enable without chip enable");

   property p_drive;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      !bus_data_oe_n_out |-> card_enable_out && $past(str_s2_ff[0]);
   endproperty
   a_drive: assert property (p_drive) else $error("bus driven without strobe");

   property p_vcard;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      1 |=> virtual_card_out == $past(high_ff[`VCARD_BIT-`ADDR_W+`HIGH_W]);
   endproperty
   a_vcard: assert property (p_vcard) else $error("virtual card select wrong");
endmodule

// ===== testbench/rom_bank_model.sv
// Memory device model on the chip side of the card.
// Assumes the card's registered address and output enables.
`timescale 1ns/1ps
module rom_bank_model
(
   input  wire logic                    core_clk_in,
   input  wire rom_card_pkg::mem_addr_t mem_addr_in,
   input  wire rom_card_pkg::dev_sel_t  output_enable_in,
   output rom_card_pkg::bus_byte_t      mem_rdata_out
);
   import rom_card_pkg::*;
   bus_byte_t last_ff;
   // ====
   // Read path. A released output shows the inverse of its last byte,
   // so a card that samples it at the wrong time never sees a match.
   always_ff @(posedge core_clk_in)
   begin
      if (|output_enable_in)
         last_ff <= mem_addr_in[7:0] ^ mem_addr_in[15:8];
   end
   assign mem_rdata_out = (|output_enable_in) ? mem_addr_in[7:0] ^ mem_addr_in[15:8] : ~last_ff;
endmodule

// ===== testbench/speech_rom_card_address_mux_test.sv
// Self-checking bench for the speech ROM card address demultiplexer.
// Assumes the package and the memory model are compiled first.
`timescale 1ns/1ps
module speech_rom_card_address_mux_test;
   import rom_card_pkg::*;
   logic       clk, rst, lh, lm, st, wr, ce, vc, oen;
   logic [2:0] sw;
   bus_byte_t  bus, rd, bdo;
   mem_addr_t  ma;
   dev_sel_t   cs, oe, we;
   int         bad_count, n_compared, cyc;
   // ====
   // Design and memory model.
   speech_rom_card_address_mux dut (.core_clk_in(clk), .sys_rst_in(rst), .bus_data_in(bus),
      .load_high_in(lh), .load_med_in(lm), .data_strobe_in(st), .write_in(wr),
      .card_block_number_in(sw), .mem_rdata_in(rd), .card_enable_out(ce), .mem_addr_out(ma),
      .chip_enable_out(cs), .output_enable_out(oe), .write_enable_out(we),
      .virtual_card_out(vc), .bus_data_out(bdo), .bus_data_oe_n_out(oen));
   rom_bank_model mem (.core_clk_in(clk), .mem_addr_in(ma), .output_enable_in(oe), .mem_rdata_out(rd));
   // Clock, and a ceiling on cycles in case the design hangs.
   initial
   begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         print_verdict;
      end
   end
   task automatic chk(input string nm, input logic [19:0] e, g);
      n_compared++;
      if (e !== g)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Inputs change at the falling edge only.
   task automatic put(input bus_byte_t b, input logic h, m, s, w);
      @(negedge clk);
      bus = b;
      lh = h;
      lm = m;
      st = s;
      wr = w;
   endtask
   task automatic load(input bus_byte_t h, m);
      put(h, 1, 0, 0, 0);
      put(h, 0, 0, 0, 0);
      put(m, 0, 1, 0, 0);
      put(m, 0, 0, 0, 0);
   endtask
   // Six cycles cover the two sync flops plus the late data copy.
   task automatic acc(input mem_addr_t a, input logic w);
      dev_sel_t e;
      logic     in;
      put(a[7:0], 0, 0, 1, w);
      repeat (6) @(negedge clk);
      in = !sw[2] && sw[1:0] == a[19:18];
      e = in ? dev_sel_t'(1) << a[17:14] : '0;
      chk("addr", a, ma);
      chk("card_en", 20'(in), 20'(ce));
      chk("chip_en", 20'(e), 20'(cs));
      chk("out_en", w ? 20'h0 : 20'(e), 20'(oe));
      chk("wr_en", w ? 20'(e) : 20'h0, 20'(we));
      chk("vcard", 20'(a[17]), 20'(vc));
      chk("oe_n", 20'(!(in && !w)), 20'(oen));
      if (in && !w)
         chk("rdata", 20'(a[7:0] ^ a[15:8]), 20'(bdo));
   endtask
   task automatic t_reset;
      chk("rst_card_en", 20'h0, 20'(ce));
      chk("rst_oe_n", 20'h1, 20'(oen));
      chk("rst_addr", 20'h0, ma);
      $display("t_reset done");
   endtask
   // Upper nibble of the high byte must be dropped.
   task automatic t_read;
      sw = 3'h1;
      load(8'hF6, 8'hA7);
      acc(20'h6_A73C, 0);
      acc(20'h6_A7FF, 0);
      acc(20'h6_A700, 1);
      load(8'h14, 8'h5A);
      acc(20'h4_5A81, 0);
      $display("t_read done");
   endtask
   task automatic t_block;
      load(8'h0B, 8'h12);
      for (int i = 0; i < 8; i++)
      begin
         sw = 3'(i);
         acc(20'hB_1234, 0);
      end
      $display("t_block done");
   endtask
   task automatic t_refuse;
      sw = 3'h2;
      put(8'h34, 0, 1, 1, 0);
      repeat (6) @(negedge clk);
      chk("busy_out_en", 20'h0, 20'(oe));
      chk("busy_oe_n", 20'h1, 20'(oen));
      put(8'h34, 0, 0, 0, 0);
      repeat (6) @(negedge clk);
      chk("med_addr", 20'hB_3434, ma);
      $display("t_refuse done");
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      rst = 1;
      sw = 3'h0;
      bus = 8'h00;
      lh = 0;
      lm = 0;
      st = 0;
      wr = 0;
      repeat (6) @(negedge clk);
      t_reset;
      rst = 0;
      t_read;
      t_block;
      t_refuse;
      print_verdict;
   end
endmodule
